// File: bench/urh_status_regs_tb.sv
// Self-checking bench for the root hub status registers
`timescale 1ns/10ps
module urh_status_regs_tb;
    import urh_pkg::*;
    logic        core_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
    logic        power_switch_mode = 0, per_port_overcurrent = 0;
    logic        overcurrent_in = 0, xact_busy = 0, usb_suspended = 0;
    logic        reg_wait, resume_event, port_cmd_valid;
    logic [7:0]  reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata, port_cmd_data, rd_val;
    logic [NUM_PORTS-1:0] port_power_mask = 0, connect_change_flag = 0;
    logic [NUM_PORTS-1:0] port_power_state, port_cmd_select;
    logic [NUM_PORTS-1:0][15:0] port_status_in = {16'h0002, 16'h0005};
    logic [NUM_PORTS-1:0][15:0] port_change_in = {16'h0010, 16'h0001};
    int          fail_count = 0, checks_done = 0, i;
    urh_status_regs u_urh_status_regs (.core_clk(core_clk),
        .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_wait(reg_wait), .power_switch_mode(power_switch_mode),
        .per_port_overcurrent(per_port_overcurrent),
        .port_power_mask(port_power_mask), .overcurrent_in(overcurrent_in),
        .xact_busy(xact_busy), .usb_suspended(usb_suspended),
        .resume_event(resume_event), .connect_change_flag(connect_change_flag),
        .port_status_in(port_status_in), .port_change_in(port_change_in),
        .port_power_state(port_power_state), .port_cmd_valid(port_cmd_valid),
        .port_cmd_select(port_cmd_select), .port_cmd_data(port_cmd_data));
    // Clock at 200 MHz
    always #2.5 core_clk = ~core_clk;
    // ========================================
    // Bus cycles and comparison
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk) #1 {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(posedge core_clk) #1 reg_wr = 0;
    endtask : wr
    task chk(input logic [31:0] got, exp, m);
        checks_done++;
        if ((got & m) !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task rc(input logic [7:0] a, input logic [31:0] exp, m = '1);
        @(posedge core_clk) #1 {reg_addr, reg_rd} = {a, 1'b1};
        @(posedge core_clk) #1 reg_rd = 0;
        chk(reg_rdata, exp, m);
    endtask : rc
    task results;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    // Watchdog on a hung run
    initial begin
        #20000 fail_count++;
        results;
    end
    // ========================================
    // Scenarios
    initial begin
        repeat (16) @(posedge core_clk);
        #1 sys_rst = 0;
        rc(8'h50, 0);
        rc(8'h54, 32'h00010005);
        rc(8'h5C, 0);
        wr(8'h50, 32'h00008000);
        wr(8'h50, 0);
        rc(8'h50, 32'h00008000);
        {usb_suspended, connect_change_flag} = 3'b110;
        repeat (2) @(posedge core_clk);
        #1 chk(32'(resume_event), 1, 1);
        wr(8'h50, 32'h80000000);
        rc(8'h50, 0);
        chk(32'(resume_event), 0, 1);
        overcurrent_in = 1;
        repeat (4) @(posedge core_clk);
        rc(8'h50, 32'h00020002);
        wr(8'h50, 32'h00020000);
        rc(8'h50, 32'h00000002);
        per_port_overcurrent = 1;
        repeat (3) @(posedge core_clk);
        rc(8'h50, 0, 2);
        wr(8'h50, 32'h00010000);
        chk(32'(port_power_state), 3, 3);
        rc(8'h58, 32'h00100102);
        wr(8'h50, 32'h00000001);
        chk(32'(port_power_state), 0, 3);
        {power_switch_mode, port_power_mask, xact_busy} = 4'b1011;
        wr(8'h50, 32'h00010000);
        chk(32'(port_power_state), 2, 3);
        wr(8'h54, 32'h00000100);
        // Second port write while one is pending is refused
        @(posedge core_clk) #1 {reg_addr, reg_wr} = {8'h58, 1'b1};
        #1 chk(32'(reg_wait), 1, 1);
        @(posedge core_clk) #1 reg_wr = 0;
        repeat (2) @(posedge core_clk);
        #1 chk(32'(port_cmd_valid), 0, 1);
        chk(32'(reg_wait), 0, 1);
        chk(32'(port_power_state), 2, 3);
        xact_busy = 0;
        for (i = 0; i < 8 && port_cmd_valid !== 1; i++) @(posedge core_clk) #1;
        chk(port_cmd_data, 32'h00000100, '1);
        chk(32'(port_cmd_select), 1, 3);
        chk(32'(port_power_state), 3, 3);
        wr(8'h50, 32'h00000001);
        chk(32'(port_power_state), 1, 3);
        wr(8'h54, 32'h00000200);
        @(posedge core_clk) #1 chk(32'(port_power_state), 0, 3);
        results;
    end
endmodule : urh_status_regs_tb

// File: bench/urh_sva.sv
// Assertions on the ports of the root hub status registers
`timescale 1ns/10ps
module urh_sva
    import urh_pkg::*;
(
    // Clock and reset
    input wire logic                          core_clk,
    input wire logic                          sys_rst,
    // Register access
    input wire logic                          reg_wr,
    input wire logic                          reg_rd,
    input wire logic                          reg_wait,
    input wire logic [7:0]                    reg_addr,
    input wire logic [31:0]                   reg_wdata,
    input wire logic [31:0]                   reg_rdata,
    // Configuration and hub state
    input wire logic                          power_switch_mode,
    input wire logic                          per_port_overcurrent,
    input wire logic                          overcurrent_in,
    input wire logic                          xact_busy,
    input wire logic                          usb_suspended,
    input wire logic                          resume_event,
    // Per-port signals
    input wire logic [urh_pkg::NUM_PORTS-1:0] port_power_mask,
    input wire logic [urh_pkg::NUM_PORTS-1:0] port_power_state,
    input wire logic [urh_pkg::NUM_PORTS-1:0] connect_change_flag,
    input wire logic                          port_cmd_valid,
    input wire logic [urh_pkg::NUM_PORTS-1:0] port_cmd_select,
    input wire logic [31:0]                   port_cmd_data
);
    import urh_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // Hub register accesses
    wire hub_wr = reg_wr && reg_addr == OFS_HUB_STATUS;
    wire hub_rd = reg_rd && reg_addr == OFS_HUB_STATUS;
    // ========================================
    // Reads
    zero_bits_a: assert property (hub_rd |=>
        !(reg_rdata & 32'hFFFD7FFD)) else $error("hub bits not zero");
    oc_port_a: assert property (hub_rd && per_port_overcurrent
        |=> !reg_rdata[1]) else $error("global oc flag not zero");
    oc_glob_a: assert property (hub_rd && !per_port_overcurrent
        |=> reg_rdata[1] == $past(overcurrent_in))
        else $error("oc flag wrong");
    unmapped_a: assert property (reg_rd && reg_addr != 8'h50 &&
        reg_addr != 8'h54 && reg_addr != 8'h58 |=> !reg_rdata)
        else $error("unmapped read not zero");
    // ========================================
    // Power commands
    pwr_on_a: assert property (hub_wr && reg_wdata[16] &&
        !power_switch_mode |=> &port_power_state) else $error("power on");
    pwr_off_a: assert property (hub_wr && reg_wdata[0] &&
        !reg_wdata[16] && !power_switch_mode |=> !port_power_state)
        else $error("power off");
    pp_set_a: assert property (hub_wr && reg_wdata[16] &&
        power_switch_mode |=> &(port_power_state | $past(port_power_mask)))
        else $error("unmasked port not powered");
    pp_mask_a: assert property (hub_wr && power_switch_mode |=>
        !((port_power_state ^ $past(port_power_state)) &
        $past(port_power_mask))) else $error("masked port changed");
    // ========================================
    // Deferral and resume
    defer_a: assert property (port_cmd_valid |->
        !$past(xact_busy) && $onehot(port_cmd_select))
        else $error("port write released during transaction");
    release_a: assert property (reg_wr && reg_addr == 8'h54 &&
        !reg_wait ##1 !xact_busy |=> port_cmd_valid &&
        port_cmd_data == $past(reg_wdata, 2)) else $error("write lost");
    resume_a: assert property (resume_event |->
        $past(usb_suspended && |connect_change_flag))
        else $error("resume without cause");
endmodule : urh_sva

bind urh_status_regs urh_sva u_urh_sva (.core_clk(core_clk),
    .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wait(reg_wait), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .port_cmd_data(port_cmd_data),
    .power_switch_mode(power_switch_mode),
    .per_port_overcurrent(per_port_overcurrent),
    .overcurrent_in(overcurrent_in), .xact_busy(xact_busy),
    .usb_suspended(usb_suspended), .resume_event(resume_event),
    .port_cmd_valid(port_cmd_valid), .port_power_mask(port_power_mask),
    .port_power_state(port_power_state),
    .connect_change_flag(connect_change_flag),
    .port_cmd_select(port_cmd_select));

// File: design/urh_pkg.sv
// Constants for the root hub status register block
package urh_pkg;
    // ========================================
    // Register map
    localparam int unsigned NUM_PORTS       = 2;
    localparam logic [7:0]  OFS_HUB_STATUS  = 8'h50;
    localparam logic [7:0]  OFS_PORT_STATUS = 8'h54;
    localparam logic [7:0]  PORT_STRIDE     = 8'h04;
    localparam logic [31:0] RESET_VALUE     = 32'h00000000;
    // ========================================
    // Hub status field positions
    localparam int unsigned BIT_CLR_WAKE    = 31;
    localparam int unsigned BIT_OC_CHANGE   = 17;
    localparam int unsigned BIT_SET_POWER   = 16;
    localparam int unsigned BIT_WAKE_EN     = 15;
    localparam int unsigned BIT_OC_FLAG     = 1;
    localparam int unsigned BIT_CLR_POWER   = 0;
    // ========================================
    // Port status field positions
    localparam int unsigned BIT_PORT_SET_PWR = 8;
    localparam int unsigned BIT_PORT_CLR_PWR = 9;
    localparam int unsigned HALF_WIDTH       = 16;
    // Deferral state of a port status write
    typedef enum logic [1:0] {
        URH_IDLE = 2'b01,
        URH_PEND = 2'b10
    } urh_state_t;
endpackage : urh_pkg

// File: design/urh_status_regs.sv
// Root hub status and per-port status registers
`timescale 1ns/10ps

// Function
// - Writing one at bit 31 clears the wake enable; zero does nothing.
// - Overcurrent change flag sets on any flag change; write one clears.
// - Hub status bits 16 and 0 always read zero.
// - Bit 16 write one powers all ports, or unmasked ports per-port.
// - Bit 0 write one unpowers all ports, or unmasked ports per-port.
// - Wake enable makes connect change a resume event from suspend.
// - Writing one at bit 15 sets the wake enable; zero does nothing.
// - Global overcurrent flag reads one during overcurrent, else zero.
// - With per-port overcurrent protection the global flag reads zero.
// - One port status register per downstream port.
// - Port status writes wait until the running bus transaction ends.
// - Port status in low half, change flags in high half.
// - Masked ports obey only per-port power commands in per-port mode.
module urh_status_regs
    import urh_pkg::*;
(
    // Clock and reset
    input  wire logic                          core_clk,
    input  wire logic                          sys_rst,
    // Register access
    input  wire logic [7:0]                    reg_addr,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    input  wire logic [31:0]                   reg_wdata,
    output logic      [31:0]                   reg_rdata,
    output logic                               reg_wait,
    // Configuration
    input  wire logic                          power_switch_mode,
    input  wire logic                          per_port_overcurrent,
    input  wire logic [urh_pkg::NUM_PORTS-1:0] port_power_mask,
    // Hub and controller state
    input  wire logic                          overcurrent_in,
    input  wire logic                          xact_busy,
    input  wire logic                          usb_suspended,
    output logic                               resume_event,
    // Port state machines
    input  wire logic [urh_pkg::NUM_PORTS-1:0] connect_change_flag,
    input  wire logic [urh_pkg::NUM_PORTS-1:0][15:0] port_status_in,
    input  wire logic [urh_pkg::NUM_PORTS-1:0][15:0] port_change_in,
    output logic      [urh_pkg::NUM_PORTS-1:0] port_power_state,
    output logic                               port_cmd_valid,
    output logic      [urh_pkg::NUM_PORTS-1:0] port_cmd_select,
    output logic      [31:0]                   port_cmd_data
);
    import urh_pkg::*;

    // ========================================
    // Decode
    logic                 hub_wr;
    logic [NUM_PORTS-1:0] port_hit;
    logic                 port_wr;
    logic                 global_oc;
    logic                 oc_prev;
    logic                 device_wake_enable;
    logic                 global_overcurrent_change;
    logic                 set_all_power_cmd;
    logic                 clear_all_power_cmd;
    logic                 clear_wake_enable_cmd;
    urh_state_t           state;
    logic [NUM_PORTS-1:0] pend_select;
    logic [31:0]          pend_data;
    logic                 apply;

    // Hub write strobe and command bits
    assign hub_wr                = reg_wr && (reg_addr == OFS_HUB_STATUS);
    assign set_all_power_cmd     = hub_wr && reg_wdata[BIT_SET_POWER];
    assign clear_all_power_cmd   = hub_wr && reg_wdata[BIT_CLR_POWER];
    assign clear_wake_enable_cmd = hub_wr && reg_wdata[BIT_CLR_WAKE];

    // One address per downstream port
    generate
        for (genvar i = 0; i < NUM_PORTS; i++) begin : g_hit
            localparam logic [7:0] PORT_OFS =
                8'(OFS_PORT_STATUS + PORT_STRIDE * i);
            assign port_hit[i] = (reg_addr == PORT_OFS);
        end
    endgenerate
    assign port_wr = reg_wr && (port_hit != '0);

    // Global flag masked when overcurrent is reported per port
    assign global_oc = per_port_overcurrent ? 1'b0 : overcurrent_in;

    // ========================================
    // Hub status bits
    // Wake enable, clear wins only when no set in same write
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            device_wake_enable <= 1'b0;
        end else if (hub_wr && reg_wdata[BIT_WAKE_EN]) begin
            device_wake_enable <= 1'b1;
        end else if (clear_wake_enable_cmd) begin
            device_wake_enable <= 1'b0;
        end
    end

    // Overcurrent change, a new change wins over the clear
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            oc_prev                   <= 1'b0;
            global_overcurrent_change <= 1'b0;
        end else begin
            oc_prev <= global_oc;
            if (global_oc != oc_prev) begin
                global_overcurrent_change <= 1'b1;
            end else if (hub_wr && reg_wdata[BIT_OC_CHANGE]) begin
                global_overcurrent_change <= 1'b0;
            end
        end
    end

    // Resume request on connect change while suspended
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            resume_event <= 1'b0;
        end else begin
            resume_event <= device_wake_enable && usb_suspended
                            && (connect_change_flag != '0);
        end
    end

    // ========================================
    // Deferred port status writes
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state       <= URH_IDLE;
            pend_select <= '0;
            pend_data   <= RESET_VALUE;
        end else begin
            case (state)
                URH_IDLE: begin
                    if (port_wr) begin
                        state       <= URH_PEND;
                        pend_select <= port_hit;
                        pend_data   <= reg_wdata;
                    end
                end
                URH_PEND: begin
                    if (!xact_busy) begin
                        state <= URH_IDLE;
                    end
                end
                default: begin
                    state <= URH_IDLE;
                end
            endcase
        end
    end
    assign apply    = (state == URH_PEND) && !xact_busy;
    assign reg_wait = (state == URH_PEND) && port_wr;

    // Forward the released write to the port logic
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            port_cmd_valid  <= 1'b0;
            port_cmd_select <= '0;
            port_cmd_data   <= RESET_VALUE;
        end else begin
            port_cmd_valid  <= apply;
            port_cmd_select <= apply ? pend_select : '0;
            port_cmd_data   <= apply ? pend_data : RESET_VALUE;
        end
    end

    // ========================================
    // Port power
    generate
        for (genvar i = 0; i < NUM_PORTS; i++) begin : g_pwr
            logic follows_global;
            logic own_set;
            logic own_clr;
            assign follows_global = !power_switch_mode
                                    || !port_power_mask[i];
            assign own_set = apply && pend_select[i] && !follows_global
                             && pend_data[BIT_PORT_SET_PWR];
            assign own_clr = apply && pend_select[i] && !follows_global
                             && pend_data[BIT_PORT_CLR_PWR];
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    port_power_state[i] <= 1'b0;
                end else if ((set_all_power_cmd && follows_global)
                             || own_set) begin
                    port_power_state[i] <= 1'b1;
                end else if ((clear_all_power_cmd && follows_global)
                             || own_clr) begin
                    port_power_state[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // ========================================
    // Read data
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            reg_rdata <= RESET_VALUE;
        end else if (reg_rd) begin
            reg_rdata <= RESET_VALUE;
            if (reg_addr == OFS_HUB_STATUS) begin
                reg_rdata[BIT_OC_CHANGE] <= global_overcurrent_change;
                reg_rdata[BIT_WAKE_EN]   <= device_wake_enable;
                reg_rdata[BIT_OC_FLAG]   <= global_oc;
                // Local power bits 16 and 0 are never set here
            end
            for (int i = 0; i < NUM_PORTS; i++) begin
                if (port_hit[i]) begin
                    reg_rdata <= {port_change_in[i],
                                  port_status_in[i]};
                    reg_rdata[BIT_PORT_SET_PWR] <= port_power_state[i];
                end
            end
        end
    end
endmodule : urh_status_regs
